// ==== hdl/hdlcr_pkg.sv ====
// Package of constants and types for the remote unit responder.
package hdlcr_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS     = 40000;
  localparam int RESP_MIN_PS       = 4000000;
  localparam int RESP_MAX_PS       = 512000000;
  localparam int TICK_PS           = 4125000;
  localparam int TICK_PERIOD_NS_X  = 4125;
  // A least time rounds up, a longest time rounds down.
  localparam int RESP_MIN_CYC      = (RESP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESP_MAX_CYC      = RESP_MAX_PS / CLK_PERIOD_PS;
  // The tick is 4.125 us; rate kept as a fraction of 1000 cycles to avoid drift.
  localparam int TICK_NUM          = 1000;
  localparam int TICK_DEN          = TICK_PERIOD_NS_X * 1000 / (CLK_PERIOD_PS / 1000) / 1000;

  // ---------------------------------------------------------------
  // Frame format
  // ---------------------------------------------------------------
  localparam logic [2:0]  RB_NODE      = 3'h3;
  localparam logic [2:0]  RB_UNIT      = 3'h5;
  localparam logic [2:0]  RB_ZERO      = 3'h0;
  localparam logic [15:0] FCS_PRESET   = 16'hFFFF;
  localparam logic [15:0] FCS_GOOD     = 16'hF0B8;
  localparam logic [15:0] FCS_POLY_REV = 16'h8408;
  localparam logic [7:0]  MIN_BYTES    = 8'h04;
  localparam int          NUM_UNITS    = 4;
  localparam int          NUM_IDS      = 4;

  // ---------------------------------------------------------------
  // Error status bits
  // ---------------------------------------------------------------
  localparam int ERR_SUM   = 0;
  localparam int ERR_FID   = 1;
  localparam int ERR_CNT   = 2;
  localparam int ERR_RB    = 3;
  localparam int ERR_LONG  = 4;
  localparam int ERR_ZRB   = 5;
  localparam int ERR_OVR   = 6;
  localparam int ERR_FCS   = 7;
  localparam int ERR_SHORT = 8;

  typedef enum logic [1:0] {HDLCR_SINGLE, HDLCR_MULTI, HDLCR_PROBE} hdlcr_mode_t;
  typedef enum {ST_INIT, ST_IDLE, ST_RECV, ST_CHECK, ST_WAIT, ST_RESP, ST_RECOVER} hdlcr_state_t;

endpackage : hdlcr_pkg

// ==== hdl/hdlcr_fcs.sv ====
// Frame check sequence accumulator, one byte per update.
`timescale 1ns/1ps
module hdlcr_fcs (
  input  wire logic        ref_clk,  // System clock.
  input  wire logic        sys_rst,  // Asynchronous reset.
  input  wire logic        clear,    // Preset at frame start.
  input  wire logic        upd,      // Fold in one byte.
  input  wire logic [7:0]  din,      // Byte, least bit first.
  output logic      [15:0] crc       // Running residue.
);

  logic [15:0] crc_r;
  logic [15:0] crc_nxt;

  function automatic logic [15:0] hdlcr_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] t;
    t = c;
    for (int i = 0; i < 8; i++) begin
      if (t[0] ^ d[i]) begin
        t = (t >> 1) ^ hdlcr_pkg::FCS_POLY_REV;
      end else begin
        t = t >> 1;
      end
    end
    return t;
  endfunction : hdlcr_step

  always_comb begin
    crc_nxt = crc_r;
    if (clear) begin
      crc_nxt = hdlcr_pkg::FCS_PRESET;
    end else if (upd) begin
      crc_nxt = hdlcr_step(crc_r, din);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      crc_r <= hdlcr_pkg::FCS_PRESET;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crc = crc_r;

endmodule : hdlcr_fcs

// ==== hdl/hdlcr_responder.sv ====
// Remote unit responder: frame screening, response timing, experiment time, records.
`timescale 1ns/1ps
module hdlcr_responder (
  input  wire logic        ref_clk,        // 25 MHz system clock.
  input  wire logic        sys_rst,        // Asynchronous reset, active high.
  input  wire logic [1:0]  mode,           // Operating mode.
  input  wire logic [31:0] unit_addr,      // Four unit addresses, unit 0 low.
  input  wire logic [3:0]  unit_en,        // Units enabled on this interface.
  input  wire logic [31:0] frame_ids,      // Four defined frame IDs, shared by all units.
  input  wire logic [31:0] frame_lens,     // Expected byte count per frame ID.
  input  wire logic [7:0]  max_bytes,      // Long frame limit.
  input  wire logic [15:0] resp_delay,     // Extra response delay in cycles.
  input  wire logic [7:0]  recover_cyc,    // Recovery period in cycles.
  input  wire logic        init_done,      // Local initialisation finished.
  input  wire logic        proc_sync_run,  // Processor sync line, high is RUN.
  input  wire logic        rx_start,       // Opening of a frame.
  input  wire logic        rx_valid,       // Received byte strobe.
  input  wire logic [7:0]  rx_data,        // Received byte.
  input  wire logic        rx_end,         // Closing flag seen.
  input  wire logic [2:0]  rx_resid,       // Residual bits at close.
  input  wire logic        rx_overrun,     // Receive buffer overwritten.
  input  wire logic        rx_abort,       // Abort seen on line.
  input  wire logic        rx_idle,        // Idle seen on line.
  output logic             unit_sync_run,  // Own sync line, high is RUN.
  output logic             rx_ready,       // Ready to accept a frame.
  output logic             resp_start,     // Start the response frame.
  output logic [1:0]       resp_unit,      // Unit that answers.
  output logic [1:0]       resp_sel,       // Frame ID slot that picks the answer.
  output logic             rec_valid,      // Frame record strobe.
  output logic [7:0]       rec_count,      // Bytes without flags and check.
  output logic [23:0]      rec_time,       // Receive time stamp.
  output logic [7:0]       rec_addr,       // Address field.
  output logic [7:0]       rec_fid,        // Frame ID field.
  output logic [15:0]      rec_seq,        // Sequential frame count field.
  output logic [15:0]      rec_err,        // Error status.
  output logic [23:0]      exp_time        // Experiment tick count.
);

  localparam int RESP_MIN = hdlcr_pkg::RESP_MIN_CYC;
  localparam int RESP_MAX = hdlcr_pkg::RESP_MAX_CYC;

  // -----------------------------------------------------------------
  // Experiment time
  // -----------------------------------------------------------------
  logic        sync_d_r,  sync_d_nxt;
  logic        run_r,     run_nxt;
  logic [9:0]  frac_r,    frac_nxt;
  logic [23:0] time_r,    time_nxt;
  logic        usync_r,   usync_nxt;

  // Ticks are counted as 8 per 825 cycles, 1000 ticks per 103125 cycles, so 4.125 us
  // becomes 103.125 cycles; the fraction accumulator keeps the long-run rate exact.
  localparam logic [9:0] FRAC_STEP = 10'd8;
  localparam logic [9:0] FRAC_WRAP = 10'd825;

  always_comb begin
    sync_d_nxt = proc_sync_run;
    run_nxt    = run_r;
    frac_nxt   = frac_r;
    time_nxt   = time_r;
    usync_nxt  = init_done;
    if (proc_sync_run && !sync_d_r) begin
      run_nxt  = 1'b1;
      frac_nxt = '0;
      time_nxt = '0;
    end else if (!proc_sync_run) begin
      run_nxt  = 1'b0;
    end else if (run_r) begin
      if (frac_r + FRAC_STEP >= FRAC_WRAP) begin
        frac_nxt = 10'(frac_r + FRAC_STEP - FRAC_WRAP);
        time_nxt = 24'(time_r + 24'd1);
      end else begin
        frac_nxt = 10'(frac_r + FRAC_STEP);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_d_r <= 1'b0;
      run_r    <= 1'b0;
      frac_r   <= '0;
      time_r   <= '0;
      usync_r  <= 1'b0;
    end else begin
      sync_d_r <= sync_d_nxt;
      run_r    <= run_nxt;
      frac_r   <= frac_nxt;
      time_r   <= time_nxt;
      usync_r  <= usync_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Frame reception
  // -----------------------------------------------------------------
  hdlcr_pkg::hdlcr_state_t st_r, st_nxt;
  logic [7:0]  cnt_r,   cnt_nxt;
  logic [7:0]  sum_r,   sum_nxt;
  logic [7:0]  addr_r,  addr_nxt;
  logic [7:0]  fid_r,   fid_nxt;
  logic [15:0] seq_r,   seq_nxt;
  logic [7:0]  last1_r, last1_nxt;
  logic [7:0]  last2_r, last2_nxt;
  logic [15:0] err_r,   err_nxt;
  logic [2:0]  resid_r, resid_nxt;
  logic        ovr_r,   ovr_nxt;
  logic [23:0] stamp_r, stamp_nxt;
  logic [15:0] wait_r,  wait_nxt;
  logic [1:0]  unit_r,  unit_nxt;
  logic [1:0]  sel_r,   sel_nxt;
  logic        go_r,    go_nxt;
  logic        recv_r,  recv_nxt;
  logic [15:0] crc;
  logic        fcs_clr;
  logic        fcs_upd;

  hdlcr_fcs hdlcr_fcs_inst (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .clear   (fcs_clr),
    .upd     (fcs_upd),
    .din     (rx_data),
    .crc     (crc)
  );

  function automatic logic [7:0] hdlcr_byte(input logic [31:0] v, input int i);
    return v[i*8 +: 8];
  endfunction : hdlcr_byte

  // Address match and frame ID lookup, combinational on the held fields.
  logic       hit;
  logic [1:0] hit_unit;
  logic       fid_ok;
  logic [1:0] fid_slot;
  logic       is_probe;

  always_comb begin
    hit      = 1'b0;
    hit_unit = '0;
    fid_ok   = 1'b0;
    fid_slot = '0;
    is_probe = (mode == 2'(hdlcr_pkg::HDLCR_PROBE));
    for (int u = hdlcr_pkg::NUM_UNITS - 1; u >= 0; u--) begin
      if (unit_en[u] && (u == 0 || mode == 2'(hdlcr_pkg::HDLCR_MULTI)) && hdlcr_byte(unit_addr, u) == addr_r) begin
        hit      = 1'b1;
        hit_unit = 2'(u);
      end
    end
    for (int f = hdlcr_pkg::NUM_IDS - 1; f >= 0; f--) begin
      if (hdlcr_byte(frame_ids, f) == fid_r) begin
        fid_ok   = 1'b1;
        fid_slot = 2'(f);
      end
    end
  end

  // abort and idle are not inputs to any decision
  logic unused_line;
  assign unused_line = rx_abort | rx_idle;

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    sum_nxt   = sum_r;
    addr_nxt  = addr_r;
    fid_nxt   = fid_r;
    seq_nxt   = seq_r;
    last1_nxt = last1_r;
    last2_nxt = last2_r;
    err_nxt   = err_r;
    resid_nxt = resid_r;
    ovr_nxt   = ovr_r;
    stamp_nxt = stamp_r;
    wait_nxt  = wait_r;
    unit_nxt  = unit_r;
    sel_nxt   = sel_r;
    go_nxt    = 1'b0;
    recv_nxt  = 1'b0;
    fcs_clr   = 1'b0;
    fcs_upd   = 1'b0;
    case (st_r)
      hdlcr_pkg::ST_INIT: begin
        if (init_done) begin
          st_nxt = hdlcr_pkg::ST_IDLE;
        end
      end
      hdlcr_pkg::ST_IDLE: begin
        if (rx_start) begin
          st_nxt    = hdlcr_pkg::ST_RECV;
          cnt_nxt   = '0;
          sum_nxt   = '0;
          ovr_nxt   = 1'b0;
          seq_nxt   = '0;
          stamp_nxt = time_r;
          fcs_clr   = 1'b1;
        end
      end
      hdlcr_pkg::ST_RECV: begin
        if (rx_valid) begin
          fcs_upd   = 1'b1;
          last2_nxt = last1_r;
          last1_nxt = rx_data;
          if (cnt_r != 8'hFF) begin
            cnt_nxt = 8'(cnt_r + 8'd1);
          end
          if (cnt_r == 8'd0) begin
            addr_nxt = rx_data;
          end
          if (cnt_r == 8'd1) begin
            fid_nxt = rx_data;
          end
          if (cnt_r == 8'd2) begin
            seq_nxt[15:8] = rx_data;
          end
          if (cnt_r == 8'd3) begin
            seq_nxt[7:0] = rx_data;
          end
          // The sum runs two bytes behind, so the check bytes stay out of it.
          if (cnt_r >= 8'd2) begin
            sum_nxt = 8'(sum_r + last2_r);
          end
        end
        if (rx_overrun) begin
          ovr_nxt = 1'b1;
        end
        if (rx_end) begin
          resid_nxt = rx_resid;
          st_nxt    = hdlcr_pkg::ST_CHECK;
        end
      end
      hdlcr_pkg::ST_CHECK: begin
        err_nxt = '0;
        if (cnt_r < hdlcr_pkg::MIN_BYTES) begin
          err_nxt[hdlcr_pkg::ERR_SHORT] = 1'b1;
        end
        if (crc != hdlcr_pkg::FCS_GOOD) begin
          err_nxt[hdlcr_pkg::ERR_FCS] = 1'b1;
        end
        if (ovr_r) begin
          err_nxt[hdlcr_pkg::ERR_OVR] = 1'b1;
        end
        if (resid_r == hdlcr_pkg::RB_ZERO) begin
          err_nxt[hdlcr_pkg::ERR_ZRB] = 1'b1;
        end else if (resid_r != hdlcr_pkg::RB_UNIT && !(is_probe && resid_r == hdlcr_pkg::RB_NODE)) begin
          // residual count
          // Commands to a remote unit carry five bits; node frames pass only while probing.
          err_nxt[hdlcr_pkg::ERR_RB] = 1'b1;
        end
        if (!is_probe) begin
          if (cnt_r >= 8'd3 && sum_r != 8'd0) begin
            err_nxt[hdlcr_pkg::ERR_SUM] = 1'b1;
          end
          if (!fid_ok) begin
            err_nxt[hdlcr_pkg::ERR_FID] = 1'b1;
          end
          else if (8'(cnt_r - 8'd2) != hdlcr_byte(frame_lens, int'(fid_slot))) begin
            err_nxt[hdlcr_pkg::ERR_CNT] = 1'b1;
          end
          if (8'(cnt_r - 8'd2) > max_bytes) begin
            err_nxt[hdlcr_pkg::ERR_LONG] = 1'b1;
          end
        end
        recv_nxt = is_probe || hit;
        unit_nxt = hit_unit;
        sel_nxt  = fid_slot;
        // clip to window end
        // Clipping here keeps a huge delay from wrapping round or firing early.
        if ({1'b0, resp_delay} > 17'(RESP_MAX - RESP_MIN)) begin
          wait_nxt = 16'(RESP_MAX - 2);
        end else begin
          wait_nxt = 16'(RESP_MIN - 2) + resp_delay;
        end
        if (!is_probe && hit && err_nxt == '0) begin
          st_nxt = hdlcr_pkg::ST_WAIT;
        end else begin
          st_nxt = hdlcr_pkg::ST_RECOVER;
          wait_nxt = 16'(recover_cyc);
        end
      end
      hdlcr_pkg::ST_WAIT: begin
        if (wait_r == '0) begin
          go_nxt   = 1'b1;
          st_nxt   = hdlcr_pkg::ST_RECOVER;
          wait_nxt = 16'(recover_cyc);
        end else begin
          wait_nxt = 16'(wait_r - 16'd1);
        end
      end
      hdlcr_pkg::ST_RECOVER: begin
        if (wait_r == '0) begin
          st_nxt = hdlcr_pkg::ST_IDLE;
        end else begin
          wait_nxt = 16'(wait_r - 16'd1);
        end
      end
      default: begin
        st_nxt = hdlcr_pkg::ST_INIT;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r    <= hdlcr_pkg::ST_INIT;
      cnt_r   <= '0;
      sum_r   <= '0;
      addr_r  <= '0;
      fid_r   <= '0;
      seq_r   <= '0;
      last1_r <= '0;
      last2_r <= '0;
      err_r   <= '0;
      resid_r <= '0;
      ovr_r   <= 1'b0;
      stamp_r <= '0;
      wait_r  <= '0;
      unit_r  <= '0;
      sel_r   <= '0;
      go_r    <= 1'b0;
      recv_r  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      sum_r   <= sum_nxt;
      addr_r  <= addr_nxt;
      fid_r   <= fid_nxt;
      seq_r   <= seq_nxt;
      last1_r <= last1_nxt;
      last2_r <= last2_nxt;
      err_r   <= err_nxt;
      resid_r <= resid_nxt;
      ovr_r   <= ovr_nxt;
      stamp_r <= stamp_nxt;
      wait_r  <= wait_nxt;
      unit_r  <= unit_nxt;
      sel_r   <= sel_nxt;
      go_r    <= go_nxt;
      recv_r  <= recv_nxt;
    end
  end

  logic rdy_r;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdy_r <= 1'b0;
    end else begin
      rdy_r <= (st_nxt == hdlcr_pkg::ST_IDLE);
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign unit_sync_run = usync_r;
  assign rx_ready      = rdy_r;
  assign resp_start    = go_r;
  assign resp_unit     = unit_r;
  assign resp_sel      = sel_r;
  assign rec_valid     = recv_r;
  assign rec_count     = 8'(cnt_r - ((cnt_r >= 8'd2) ? 8'd2 : cnt_r));
  assign rec_time      = stamp_r;
  assign rec_addr      = addr_r;
  assign rec_fid       = fid_r;
  assign rec_seq       = seq_r;
  assign rec_err       = err_r;
  assign exp_time      = time_r;

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  int gap_r;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_r <= 0;
    end else if (st_r == hdlcr_pkg::ST_CHECK) begin
      gap_r <= 0;
    end else if (gap_r < RESP_MAX + 8) begin
      gap_r <= gap_r + 1;
    end
  end

  a_resp_window: assert property (@(posedge ref_clk) disable iff (sys_rst)
    resp_start |-> (gap_r >= RESP_MIN - 1 && gap_r <= RESP_MAX))
    else $error("response outside window");
  a_probe_silent: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mode == 2'(hdlcr_pkg::HDLCR_PROBE) |-> !resp_start)
    else $error("probe mode responded");
  a_err_no_resp: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r == hdlcr_pkg::ST_CHECK && err_nxt != '0) |=> st_r == hdlcr_pkg::ST_RECOVER)
    else $error("errored frame went to response");
  a_addr_screen: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r == hdlcr_pkg::ST_CHECK && !hit) |=> st_r != hdlcr_pkg::ST_WAIT)
    else $error("unaddressed frame answered");
  a_sync_init: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !init_done |=> !unit_sync_run)
    else $error("sync RUN before init");
  a_time_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(proc_sync_run) ##1 1 |=> exp_time == 24'd0)
    else $error("time not restarted");
  a_recover_busy: assert property (@(posedge ref_clk) disable iff (sys_rst)
    resp_start |-> !rx_ready)
    else $error("ready during recovery");
  a_zero_resid: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r == hdlcr_pkg::ST_CHECK && resid_r == hdlcr_pkg::RB_ZERO) |=> rec_err[hdlcr_pkg::ERR_ZRB])
    else $error("zero residual not logged");

  c_resp: cover property (@(posedge ref_clk) resp_start);
  c_probe_rec: cover property (@(posedge ref_clk) rec_valid && mode == 2'(hdlcr_pkg::HDLCR_PROBE));
  c_err_rec: cover property (@(posedge ref_clk) rec_valid && rec_err != '0);

endmodule : hdlcr_responder

// ==== verification/hdlcr_proc_model.sv ====
// Processor side model that frames command bytes onto the receive strobes.
`timescale 1ns/1ps
module hdlcr_proc_model (
  input  wire logic       ref_clk,     // System clock.
  input  wire logic       rx_ready,    // Responder idle.
  output logic            rx_start,    // Frame opening.
  output logic            rx_valid,    // Byte strobe.
  output logic      [7:0] rx_data,     // Byte.
  output logic            rx_end,      // Closing flag.
  output logic      [2:0] rx_resid,    // Residual bits.
  output logic            rx_overrun,  // Overrun flag.
  output logic            rx_abort,    // Abort seen.
  output logic            rx_idle      // Idle seen.
);
  // ---------------------------------------------
  // Frame builder
  // ---------------------------------------------
  logic [7:0] fb [$];
  initial begin
    {rx_start, rx_valid, rx_data, rx_end, rx_resid, rx_overrun, rx_abort, rx_idle} = '0;
  end
  function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ hdlcr_pkg::FCS_POLY_REV) : (c >> 1);
    end
    return c;
  endfunction : crc_b
  // Flag bits: 0 bad sum, 1 bad check, 2 overrun, 3 abort and idle; a cut above zero truncates.
  task automatic send(input logic [7:0] a, f, input logic [15:0] sq, input int nd, fl,
                      input logic [2:0] rs, input int cut, input logic [31:0] dat);
    logic [7:0]  s;
    logic [15:0] c;
    int          n;
    fb = {a, f, sq[15:8], sq[7:0]};
    for (int i = 0; i < nd; i++)
      fb.push_back(dat[8*(i%4)+:8]);
    s = 8'h00;
    foreach (fb[i])
      s += fb[i];
    fb.push_back((8'h00 - s) ^ {7'h00, fl[0]});
    c = hdlcr_pkg::FCS_PRESET;
    foreach (fb[i])
      c = crc_b(c, fb[i]);
    c = ~c ^ {15'h0000, fl[1]};
    fb.push_back(c[7:0]);
    fb.push_back(c[15:8]);
    n = (cut > 0) ? cut : fb.size();
    for (int w = 0; w < 500 && rx_ready !== 1'b1; w++)
      @(negedge ref_clk);
    @(negedge ref_clk);
    rx_start = 1'b1;
    @(negedge ref_clk);
    rx_start = 1'b0;
    for (int i = 0; i < n; i++) begin
      rx_valid = 1'b1;
      rx_data = fb[i];
      rx_overrun = fl[2] && i == 2;
      rx_abort = fl[3] && i == 3;
      rx_idle = fl[3] && i == 3;
      @(negedge ref_clk);
      {rx_valid, rx_overrun, rx_abort, rx_idle} = 4'h0;
      // A stale byte is inverted so a late sample cannot match by luck.
      rx_data = ~rx_data;
      @(negedge ref_clk);
    end
    rx_end = 1'b1;
    rx_resid = rs;
    @(negedge ref_clk);
    rx_end = 1'b0;
  endtask : send
endmodule : hdlcr_proc_model

// ==== verification/tb_hdlc_remote_unit_responder.sv ====
// Self-checking testbench of the remote unit responder.
`timescale 1ns/1ps
module tb_hdlc_remote_unit_responder;
  // ---------------------------------------------
  // Signals
  // ---------------------------------------------
  localparam logic [31:0] FIDS = 32'h8040_0100;
  localparam logic [31:0] LENS = 32'h0908_0706;
  logic        ref_clk, sys_rst, init_done, proc_sync_run, got_rec, rdy_rec;
  logic        rx_start, rx_valid, rx_end, rx_overrun, rx_abort, rx_idle;
  logic        unit_sync_run, rx_ready, resp_start, rec_valid;
  logic [1:0]  mode, resp_unit, resp_sel;
  logic [2:0]  rx_resid;
  logic [7:0]  rx_data, rec_count, rec_addr, rec_fid;
  logic [15:0] resp_delay, rec_seq, rec_err, err_f;
  logic [23:0] rec_time, exp_time, tm_f;
  logic [31:0] unit_addr;
  logic [39:0] rec_f;
  int          mismatches, checked, seed, cycles, resp_at, tn, run_at, start_at;
  hdlcr_responder hdlcr_responder_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .mode(mode),
    .unit_addr(unit_addr), .unit_en(4'hF), .frame_ids(FIDS), .frame_lens(LENS), .max_bytes(8'h0C),
    .resp_delay(resp_delay), .recover_cyc(8'h14), .init_done(init_done), .proc_sync_run(proc_sync_run),
    .rx_start(rx_start), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .rx_resid(rx_resid),
    .rx_overrun(rx_overrun), .rx_abort(rx_abort), .rx_idle(rx_idle), .unit_sync_run(unit_sync_run),
    .rx_ready(rx_ready), .resp_start(resp_start), .resp_unit(resp_unit), .resp_sel(resp_sel),
    .rec_valid(rec_valid), .rec_count(rec_count), .rec_time(rec_time), .rec_addr(rec_addr),
    .rec_fid(rec_fid), .rec_seq(rec_seq), .rec_err(rec_err), .exp_time(exp_time));
  hdlcr_proc_model hdlcr_proc_model_inst (.ref_clk(ref_clk), .rx_ready(rx_ready), .rx_start(rx_start),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .rx_resid(rx_resid),
    .rx_overrun(rx_overrun), .rx_abort(rx_abort), .rx_idle(rx_idle));
  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic watch(input int lim);
    got_rec = 1'b0;
    resp_at = 0;
    for (int i = 1; i <= lim; i++) begin
      @(posedge ref_clk);
      #1;
      if (rec_valid === 1'b1) begin
        got_rec = 1'b1;
        rdy_rec = rx_ready;
        {rec_f, err_f, tm_f} = {rec_count, rec_addr, rec_fid, rec_seq, rec_err, rec_time};
      end
      if (resp_start === 1'b1 && resp_at == 0)
        resp_at = i;
    end
  endtask : watch
  // Unit index 4 is a foreign address, slot 4 an undefined frame ID; eb -1 good, -2 record presence checked only in probe mode.
  task automatic run(input int m, ai, s, nd, fl, input logic [2:0] rs, input int cut, eb);
    logic [7:0]  a, f;
    logic [15:0] sq;
    logic [31:0] dat;
    logic        er;
    int          lo, e;
    @(negedge ref_clk);
    mode = m[1:0];
    resp_delay = $random(seed) & 16'h003F;
    a = (ai > 3) ? 8'h55 : unit_addr[8*ai+:8];
    f = (s > 3) ? 8'h77 : FIDS[8*s+:8];
    sq = $random(seed);
    dat = $random(seed);
    er = eb == -1 && ai <= 3 && (m == 1 || (m == 0 && ai == 0));
    lo = hdlcr_pkg::RESP_MIN_CYC + resp_delay;
    hdlcr_proc_model_inst.send(a, f, sq, 1 + s + nd, fl, rs, cut, dat);
    watch(lo + 40);
    if (eb != -2 || m == 2)
      check(got_rec, 1'b1);
    if (eb >= 0)
      check(err_f[eb], 1'b1);
    e = (start_at - run_at) * hdlcr_pkg::CLK_PERIOD_PS / hdlcr_pkg::TICK_PS;
    if (eb == -1 && m != 2) begin
      check({rec_f, err_f}, {8'(6 + s + nd), a, f, sq, 16'h0000});
      check(int'(tm_f) >= e - 1 && int'(tm_f) <= e + 1, 1'b1);
    end
    check(resp_at != 0, er);
    if (er) begin
      check(resp_at >= lo && resp_at <= lo + 4, 1'b1);
      check({resp_unit, resp_sel}, {ai[1:0], s[1:0]});
      check(rdy_rec, 1'b0);
    end
    $display("test %0d done", tn);
    tn++;
  endtask : run
  // ---------------------------------------------
  // Sequence
  // ---------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (rx_start === 1'b1 && rx_ready === 1'b1)
      start_at <= cycles;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 100000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    {mismatches, checked, cycles, tn, resp_at} = '0;
    seed = 36187;
    {got_rec, rdy_rec, rec_f, err_f} = '0;
    {sys_rst, init_done, proc_sync_run, mode, resp_delay} = 21'h1_0000 << 4;
    unit_addr = 32'h8382_8180;
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    check({unit_sync_run, rx_ready}, 2'b00);
    init_done = 1'b1;
    repeat (3) @(negedge ref_clk);
    check(unit_sync_run, 1'b1);
    repeat (300) @(negedge ref_clk);
    check(exp_time, 24'h00_0000);
    proc_sync_run = 1'b1;
    run_at = cycles;
    repeat (1031) @(negedge ref_clk);
    check(exp_time >= 24'd9 && exp_time <= 24'd11, 1'b1);
    run(0, 0, 0, 0, 0, 5, 0, -1);
    run(0, 0, 1, 0, 1, 5, 0, hdlcr_pkg::ERR_SUM);
    run(0, 0, 2, 0, 0, 3, 0, hdlcr_pkg::ERR_RB);
    run(0, 0, 0, 0, 0, 0, 0, hdlcr_pkg::ERR_ZRB);
    run(0, 0, 4, 0, 0, 5, 0, hdlcr_pkg::ERR_FID);
    run(0, 0, 0, 1, 0, 5, 0, hdlcr_pkg::ERR_CNT);
    run(0, 0, 0, 9, 0, 5, 0, hdlcr_pkg::ERR_LONG);
    run(0, 0, 3, 0, 4, 5, 0, hdlcr_pkg::ERR_OVR);
    run(0, 0, 1, 0, 2, 5, 0, hdlcr_pkg::ERR_FCS);
    run(0, 0, 0, 0, 0, 5, 3, hdlcr_pkg::ERR_SHORT);
    run(0, 0, 2, 0, 8, 5, 0, -1);
    run(0, 4, 0, 0, 0, 5, 0, -2);
    run(0, 1, 0, 0, 0, 5, 0, -2);
    run(2, 0, 0, 0, 0, 5, 0, -2);
    for (int k = 0; k < 16; k++)
      run(1, $random(seed) & 3, $random(seed) & 3, 0, 0, 5, 0, -1);
    complete_run();
  end
endmodule : tb_hdlc_remote_unit_responder
